// file: rtl/lpst_scan.sv
`include "lpst_regs.svh"

// Behaviour
// - column data leaves on four parallel bits
// - drivers capture data on shift clock fall
// - shift pulses per line are multiples of sixteen
// - shift clock idles from latch to next line
// - enable-chain clock falling edge advances cascade
// - chain clock pulses on every sixteenth shift
// - latch pulse moves shift registers to outputs
// - latch acts on falling edge, once per line
// - bias output toggles at configured line period
// - row clock falling edge captures frame pulse
// - frame pulse high only on last line
// - row clock steps frame pulse once per line
// - display-off high while drive is active
// - power save drops display-off within two frames
// - strap pins pick divide by four, eight, sixteen
// - reset clears state, outputs go inactive
module lpst_scan (
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  input  wire logic [1:0]           shift_divider_straps_i,
  input  wire lpst_pkg::lpst_geom_t geom_i,
  input  wire logic                 display_on_cmd_i,
  input  wire logic                 power_save_cmd_i,
  input  wire lpst_pkg::lpst_word_t pix_word_i,
  input  wire logic                 pix_valid_i,
  output logic                      pix_ready_o,
  output logic [3:0]                column_data_out_o,
  output logic                      pixel_shift_clock_o,
  output logic                      column_enable_chain_clock_o,
  output logic                      line_latch_pulse_o,
  output logic                      backplane_bias_toggle_o,
  output logic                      row_shift_clock_o,
  output logic                      frame_pulse_out_o,
  output logic                      display_off_out_o
);

  // ************************************************************
  // strap synchroniser
  // ************************************************************
  logic [1:0] strap_meta_r;
  logic [1:0] strap_sync_r;

  // straps may move during operation, so they cross like any pin
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      strap_meta_r <= `LPST_STRAP_DIV4;
      strap_sync_r <= `LPST_STRAP_DIV4;
    end else begin
      strap_meta_r <= shift_divider_straps_i;
      strap_sync_r <= strap_meta_r;
    end
  end

  // ************************************************************
  // shift period divider
  // ************************************************************
  logic rise_en;
  logic fall_en;

  lpst_div u_div (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .strap_i    (strap_sync_r),
    .rise_en_o  (rise_en),
    .fall_en_o  (fall_en)
  );

  // ************************************************************
  // column word buffer
  // ************************************************************
  lpst_pkg::lpst_word_t buf_word;
  logic                 buf_valid;
  logic                 buf_pop;

  lpst_buf2 u_buf (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_word_i   (pix_word_i),
    .in_valid_i  (pix_valid_i),
    .in_ready_o  (pix_ready_o),
    .out_word_o  (buf_word),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop)
  );

  // ************************************************************
  // sequencer state
  // ************************************************************
  lpst_pkg::lpst_state_t state_r;
  lpst_pkg::lpst_state_t state_nxt;
  logic [3:0]            bit_cnt_r;
  logic [7:0]            group_cnt_r;
  logic [8:0]            line_cnt_r;
  logic [7:0]            bias_cnt_r;
  logic [1:0]            gap_cnt_r;
  logic                  active_r;
  logic                  save_pend_r;
  logic                  save_seen_r;

  // ************************************************************
  // decode
  // ************************************************************
  logic in_shift;
  logic in_latch;
  logic in_gap;
  logic in_idle;
  logic group_end;
  logic line_end_pulse;
  logic gap_done;
  logic last_line;
  logic frame_end;
  logic bias_wrap;
  logic next_last;
  logic [8:0] line_nxt;
  logic save_stop;

  assign in_idle   = (state_r == lpst_pkg::LPST_IDLE);
  assign in_shift  = (state_r == lpst_pkg::LPST_SHIFT);
  assign in_latch  = (state_r == lpst_pkg::LPST_LATCH);
  assign in_gap    = (state_r == lpst_pkg::LPST_GAP);

  // a pulse is only emitted when a word is ready; a starved buffer
  // stretches the line instead of sending stale data
  assign buf_pop   = rise_en & in_shift & buf_valid;
  assign group_end = (bit_cnt_r == `LPST_GROUP_LAST);
  // line ends only at a full group boundary
  assign line_end_pulse = buf_pop & group_end & (group_cnt_r == geom_i.groups_m1);
  assign gap_done  = rise_en & in_gap & (gap_cnt_r == `LPST_GAP_LAST);
  assign last_line = (line_cnt_r == geom_i.lines_m1);
  assign frame_end = gap_done & last_line;
  assign line_nxt  = last_line ? 9'h000 : 9'(line_cnt_r + 9'h001);
  assign next_last = (line_nxt == geom_i.lines_m1);
  assign bias_wrap = (bias_cnt_r == geom_i.bias_lines_m1);
  // the frame end that drops drive also parks the sequencer, so no line runs blanked
  assign save_stop = frame_end & save_pend_r & (save_seen_r == `LPST_SAVE_FRAMES_LAST)
                     & ~display_on_cmd_i & ~power_save_cmd_i;

  // next state of the line sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      lpst_pkg::LPST_IDLE: begin
        if (rise_en & active_r) begin
          state_nxt = lpst_pkg::LPST_SHIFT;
        end
      end
      lpst_pkg::LPST_SHIFT: begin
        if (line_end_pulse) begin
          state_nxt = lpst_pkg::LPST_LATCH;
        end
      end
      lpst_pkg::LPST_LATCH: begin
        if (rise_en) begin
          state_nxt = lpst_pkg::LPST_GAP;
        end
      end
      lpst_pkg::LPST_GAP: begin
        if (gap_done) begin
          state_nxt = (active_r & ~save_stop) ? lpst_pkg::LPST_SHIFT : lpst_pkg::LPST_IDLE;
        end
      end
      default: begin
        state_nxt = lpst_pkg::LPST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // counters
  // ************************************************************

  // shift pulses within a group and groups within a line
  always_ff @(posedge core_clk_i) begin
    if (rst_i | in_idle) begin
      bit_cnt_r   <= 4'h0;
      group_cnt_r <= 8'h00;
    end else if (buf_pop) begin
      bit_cnt_r   <= 4'(bit_cnt_r + 4'h1);
      group_cnt_r <= group_end ? ((group_cnt_r == geom_i.groups_m1) ? 8'h00
                                  : 8'(group_cnt_r + 8'h01)) : group_cnt_r;
    end
  end

  // gap periods with the shift clock parked low
  always_ff @(posedge core_clk_i) begin
    if (rst_i | ~in_gap) begin
      gap_cnt_r <= 2'h0;
    end else if (rise_en) begin
      gap_cnt_r <= 2'(gap_cnt_r + 2'h1);
    end
  end

  // line within frame; restarts at line 0 from idle
  always_ff @(posedge core_clk_i) begin
    if (rst_i | in_idle) begin
      line_cnt_r <= 9'h000;
    end else if (gap_done) begin
      line_cnt_r <= line_nxt;
    end
  end

  // ************************************************************
  // sequencer and panel strobes
  // ************************************************************
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r                     <= lpst_pkg::LPST_IDLE;
      column_data_out_o           <= `LPST_RST_DATA;
      pixel_shift_clock_o         <= 1'b0;
      column_enable_chain_clock_o <= 1'b0;
      line_latch_pulse_o          <= 1'b0;
      row_shift_clock_o           <= 1'b0;
      frame_pulse_out_o           <= 1'b0;
    end else begin
      state_r <= state_nxt;
      // new word with the rising edge, stable over the fall
      if (buf_pop) begin
        column_data_out_o           <= buf_word.data;
        pixel_shift_clock_o         <= 1'b1;
        column_enable_chain_clock_o <= group_end;
      end else if (fall_en) begin
        pixel_shift_clock_o         <= 1'b0;
        column_enable_chain_clock_o <= 1'b0;
      end
      // latch and row clock share one half period, fall acts
      if (rise_en & in_latch) begin
        line_latch_pulse_o <= 1'b1;
        row_shift_clock_o  <= 1'b1;
      end else if (fall_en) begin
        line_latch_pulse_o <= 1'b0;
        row_shift_clock_o  <= 1'b0;
      end
      // frame pulse moves only at line start, far from the row clock fall
      if (rise_en & in_idle & active_r) begin
        frame_pulse_out_o <= (geom_i.lines_m1 == 9'h000);
      end else if (gap_done) begin
        frame_pulse_out_o <= active_r & next_last;
      end
      // blanked panel sees quiet data lines
      if (in_idle) begin
        column_data_out_o <= `LPST_RST_DATA;
      end
    end
  end

  // ************************************************************
  // backplane bias
  // ************************************************************

  // toggles every configured number of lines, counted at line end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      bias_cnt_r              <= 8'h00;
      backplane_bias_toggle_o <= 1'b0;
    end else if (gap_done) begin
      bias_cnt_r <= bias_wrap ? 8'h00 : 8'(bias_cnt_r + 8'h01);
      if (bias_wrap) begin
        backplane_bias_toggle_o <= ~backplane_bias_toggle_o;
      end
    end
  end

  // ************************************************************
  // display on / power save
  // ************************************************************

  // power save waits for two frame ends: the first may come at once,
  // so the second guarantees at least one whole frame, at most two
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      active_r    <= 1'b0;
      save_pend_r <= 1'b0;
      save_seen_r <= 1'b0;
    end else if (display_on_cmd_i) begin
      active_r    <= 1'b1;
      save_pend_r <= 1'b0;
      save_seen_r <= 1'b0;
    end else if (power_save_cmd_i) begin
      save_pend_r <= active_r;
      save_seen_r <= 1'b0;
    end else if (frame_end & save_pend_r) begin
      if (save_seen_r == `LPST_SAVE_FRAMES_LAST) begin
        active_r    <= 1'b0;
        save_pend_r <= 1'b0;
      end else begin
        save_seen_r <= 1'b1;
      end
    end
  end

  // level follows drive state one cycle later
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      display_off_out_o <= 1'b0;
    end else begin
      display_off_out_o <= active_r;
    end
  end

endmodule

// file: rtl/lpst_regs.svh
`ifndef LPST_REGS_SVH
`define LPST_REGS_SVH

// ************************************************************
// strap codes for the pixel shift clock divider
// ************************************************************
`define LPST_STRAP_DIV4       2'h0
`define LPST_STRAP_DIV8       2'h1
`define LPST_STRAP_DIV16      2'h2
`define LPST_STRAP_RSVD       2'h3

// ************************************************************
// divider terminal counts (period minus one) and half points
// ************************************************************
`define LPST_DIV4_LAST        4'h3
`define LPST_DIV8_LAST        4'h7
`define LPST_DIV16_LAST       4'hF
`define LPST_DIV4_HALF        4'h2
`define LPST_DIV8_HALF        4'h4
`define LPST_DIV16_HALF       4'h8

// ************************************************************
// scan geometry and timing counts
// ************************************************************
`define LPST_GROUP_LAST       4'hF
`define LPST_GAP_LAST         2'h1
`define LPST_SAVE_FRAMES_LAST 1'h1

// ************************************************************
// reset values
// ************************************************************
`define LPST_RST_DATA         4'h0
`define LPST_RST_DIV_CNT      4'h0

`endif

// file: rtl/lpst_pkg.sv
package lpst_pkg;

  // ************************************************************
  // types shared by the scan timing files
  // ************************************************************

  // one column word as it travels through the buffer
  typedef struct packed {
    logic [3:0] data;
  } lpst_word_t;

  // panel geometry from the system configuration command, minus-one coded
  typedef struct packed {
    logic [7:0] groups_m1;
    logic [8:0] lines_m1;
    logic [7:0] bias_lines_m1;
  } lpst_geom_t;

  // line sequencer states
  typedef enum logic [1:0] {
    LPST_IDLE  = 2'b00,
    LPST_SHIFT = 2'b01,
    LPST_LATCH = 2'b10,
    LPST_GAP   = 2'b11
  } lpst_state_t;

endpackage

// file: rtl/lpst_buf2.sv
module lpst_buf2 (
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire lpst_pkg::lpst_word_t in_word_i,
  input  wire logic               in_valid_i,
  output logic                    in_ready_o,
  output lpst_pkg::lpst_word_t    out_word_o,
  output logic                    out_valid_o,
  input  wire logic               out_ready_i
);

  // ************************************************************
  // two-entry store
  // ************************************************************
  lpst_pkg::lpst_word_t mem_r [0:1];
  logic                 wr_ptr_r;
  logic                 rd_ptr_r;
  logic [1:0]           cnt_r;
  logic [1:0]           cnt_nxt;
  logic                 push;
  logic                 pop;
  logic                 ready_r;
  logic                 valid_r;

  // handshakes use registered flags so both sides see flop outputs
  assign push        = in_valid_i & ready_r;
  assign pop         = out_ready_i & valid_r;
  assign cnt_nxt     = 2'(cnt_r + {1'b0, push} - {1'b0, pop});
  assign in_ready_o  = ready_r;
  assign out_valid_o = valid_r;
  assign out_word_o  = mem_r[rd_ptr_r];

  // pointers, fill level and flags
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      cnt_r    <= 2'h0;
      ready_r  <= 1'b0;
      valid_r  <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      cnt_r    <= cnt_nxt;
      ready_r  <= (cnt_nxt != 2'h2);
      valid_r  <= (cnt_nxt != 2'h0);
    end
  end

  // data entries need no reset
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_word_i;
    end
  end

endmodule

// file: rtl/lpst_div.sv
`include "lpst_regs.svh"

module lpst_div (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] strap_i,
  output logic            rise_en_o,
  output logic            fall_en_o
);

  // ************************************************************
  // strap decode
  // ************************************************************

  // reserved code runs at the slowest rate, the safest for the drivers
  function automatic logic [3:0] last_of(input logic [1:0] s);
    case (s)
      `LPST_STRAP_DIV4: last_of = `LPST_DIV4_LAST;
      `LPST_STRAP_DIV8: last_of = `LPST_DIV8_LAST;
      default:          last_of = `LPST_DIV16_LAST;
    endcase
  endfunction

  function automatic logic [3:0] half_of(input logic [1:0] s);
    case (s)
      `LPST_STRAP_DIV4: half_of = `LPST_DIV4_HALF;
      `LPST_STRAP_DIV8: half_of = `LPST_DIV8_HALF;
      default:          half_of = `LPST_DIV16_HALF;
    endcase
  endfunction

  // ************************************************************
  // period counter
  // ************************************************************
  logic [3:0] cnt_r;
  logic       wrap;

  // >= so a strap change mid-period never strands the counter
  assign wrap = (cnt_r >= last_of(strap_i));

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_r     <= `LPST_RST_DIV_CNT;
      rise_en_o <= 1'b0;
      fall_en_o <= 1'b0;
    end else begin
      cnt_r     <= wrap ? 4'h0 : 4'(cnt_r + 4'h1);
      rise_en_o <= wrap;
      fall_en_o <= (cnt_r == 4'(half_of(strap_i) - 4'h1));
    end
  end

endmodule

// file: bench/lpst_scan_checker.sv
module lpst_scan_checker (
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       display_on_cmd_i,
  input wire logic [3:0] column_data_out_o,
  input wire logic       pixel_shift_clock_o,
  input wire logic       column_enable_chain_clock_o,
  input wire logic       line_latch_pulse_o,
  input wire logic       backplane_bias_toggle_o,
  input wire logic       row_shift_clock_o,
  input wire logic       frame_pulse_out_o,
  input wire logic       display_off_out_o
);
  // ************************************************************
  // panel output checks
  // ************************************************************
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // every panel line quiet, display-off aside
  sequence all_quiet;
    {column_data_out_o, pixel_shift_clock_o, column_enable_chain_clock_o, line_latch_pulse_o,
     backplane_bias_toggle_o, row_shift_clock_o, frame_pulse_out_o} == 10'h000;
  endsequence
  // shortest half period is two cycles
  sequence latch_held;
    line_latch_pulse_o [*2];
  endsequence
  // gap after latch: shift clock stays stopped
  sequence gap_quiet;
    !pixel_shift_clock_o [*4];
  endsequence

  // reset checks must see the reset itself, so they are never disabled
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> all_quiet)
    else $error("panel output active after reset");
  a_off_in_reset: assert property (disable iff (1'b0) rst_i |=> !display_off_out_o)
    else $error("display off high after reset");
  a_on_drives_off: assert property (display_on_cmd_i |=> ##1 display_off_out_o)
    else $error("display off not high after start");
  a_data_held: assert property ($fell(pixel_shift_clock_o) |-> $stable(column_data_out_o))
    else $error("column data moved at shift fall");
  a_chain_in_shift: assert property (column_enable_chain_clock_o |-> pixel_shift_clock_o)
    else $error("chain clock outside shift pulse");
  a_latch_no_shift: assert property (line_latch_pulse_o |-> !pixel_shift_clock_o)
    else $error("shift clock during latch");
  a_row_follows_latch: assert property (row_shift_clock_o == line_latch_pulse_o)
    else $error("row clock differs from latch");
  a_latch_width: assert property ($rose(line_latch_pulse_o) |-> latch_held)
    else $error("latch pulse too short");
  a_gap_idle: assert property ($fell(line_latch_pulse_o) |-> gap_quiet)
    else $error("shift clock restarted in gap");
  a_frame_steady: assert property ($changed(frame_pulse_out_o) |-> !pixel_shift_clock_o && !line_latch_pulse_o)
    else $error("frame pulse moved inside a line");
  a_bias_steady: assert property ($changed(backplane_bias_toggle_o) |-> !pixel_shift_clock_o)
    else $error("bias moved during shift pulse");
endmodule

bind lpst_scan lpst_scan_checker u_lpst_scan_checker (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .display_on_cmd_i(display_on_cmd_i),
  .column_data_out_o(column_data_out_o), .pixel_shift_clock_o(pixel_shift_clock_o),
  .column_enable_chain_clock_o(column_enable_chain_clock_o), .line_latch_pulse_o(line_latch_pulse_o),
  .backplane_bias_toggle_o(backplane_bias_toggle_o), .row_shift_clock_o(row_shift_clock_o),
  .frame_pulse_out_o(frame_pulse_out_o), .display_off_out_o(display_off_out_o));

// file: bench/lpst_panel_model.sv
module lpst_panel_model (
  input wire logic       core_clk_i,
  input wire logic [3:0] data_i,
  input wire logic       shift_i,
  input wire logic       chain_i,
  input wire logic       latch_i,
  input wire logic       row_i,
  input wire logic       frame_i,
  input wire logic       bias_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] got_q[$];
  int         shifts, chains, line_shifts, line_chains, lines, frames, hi_cnt, hi_len, bias_last, bias_gap;
  int         edges = 0;

  // the unknown-to-low step of the first reset edge is no real edge
  always @(posedge core_clk_i) edges++;

  // ************************************************************
  // column and row driver behaviour
  // ************************************************************
  // column drivers take the word on the shift clock fall
  always @(negedge shift_i iff edges > 1) begin
    got_q.push_back(data_i);
    shifts++;
  end
  // enable cascade hands over on chain fall
  always @(negedge chain_i iff edges > 1) chains++;
  // latch fall moves the line to the outputs
  always @(negedge latch_i iff edges > 1) begin
    line_shifts = shifts;
    line_chains = chains;
    shifts = 0;
    chains = 0;
    lines++;
  end
  // row drivers shift in the frame level on row fall
  always @(negedge row_i iff edges > 1) if (frame_i) frames++;
  // bias steps measured in latched lines
  always @(bias_i iff edges > 1) begin
    bias_gap = lines - bias_last;
    bias_last = lines;
  end
  // high time in core cycles of the last shift pulse
  always @(posedge core_clk_i) begin
    if (shift_i) hi_cnt++;
    else if (hi_cnt != 0) begin
      hi_len = hi_cnt;
      hi_cnt = 0;
    end
  end
endmodule

// file: bench/tb_lpst_scan.sv
module tb_lpst_scan;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 core_clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 on_cmd = 1'b0;
  logic                 ps_cmd = 1'b0;
  logic                 pix_valid = 1'b0;
  logic                 took = 1'b0;
  logic [1:0]           straps = 2'h0;
  lpst_pkg::lpst_geom_t geom = '0;
  lpst_pkg::lpst_word_t pix_word = '0;
  wire logic            ready, shift, chain, latch, bias, row, frame, off;
  wire logic [3:0]      data;
  logic [3:0]           send_q[$];
  logic [3:0]           exp_q[$];
  int                   seed = 52270;
  int                   bad_count = 0;
  int                   checks_done = 0;
  int                   cycles = 0;
  int                   base, n, w0;

  always #20 core_clk_i = ~core_clk_i;

  lpst_scan u_lpst_scan (.core_clk_i(core_clk_i), .rst_i(rst_i), .shift_divider_straps_i(straps), .geom_i(geom),
    .display_on_cmd_i(on_cmd), .power_save_cmd_i(ps_cmd), .pix_word_i(pix_word), .pix_valid_i(pix_valid),
    .pix_ready_o(ready), .column_data_out_o(data), .pixel_shift_clock_o(shift), .column_enable_chain_clock_o(chain),
    .line_latch_pulse_o(latch), .backplane_bias_toggle_o(bias), .row_shift_clock_o(row),
    .frame_pulse_out_o(frame), .display_off_out_o(off));
  lpst_panel_model u_lpst_panel_model (.core_clk_i(core_clk_i), .data_i(data), .shift_i(shift), .chain_i(chain),
    .latch_i(latch), .row_i(row), .frame_i(frame), .bias_i(bias));

  // ************************************************************
  // word feeder and run limit
  // ************************************************************
  // a word counts as taken only if ready was high at the edge
  always @(posedge core_clk_i) took <= pix_valid & ready;
  always @(negedge core_clk_i) begin
    if (took) void'(send_q.pop_front());
    pix_valid = send_q.size() != 0;
    pix_word.data = (send_q.size() != 0) ? send_q[0] : 4'h0;
  end
  // generous ceiling: the whole sequence needs a few thousand cycles
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      final_report();
    end
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic int exp_half(logic [1:0] s);
    return (s == 2'h0) ? 2 : (s == 2'h1) ? 4 : 8; // reserved code runs as divide by sixteen
  endfunction
  task automatic chk_val(logic [31:0] got, logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic push_words(int cnt);
    logic [3:0] w;
    repeat (cnt) begin
      w = $random(seed) & 4'hF;
      send_q.push_back(w);
      exp_q.push_back(w);
    end
  endtask
  task automatic wait_lines(int t);
    while (u_lpst_panel_model.lines < t) @(negedge core_clk_i);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    geom.lines_m1 = 9'h002;
    geom.bias_lines_m1 = 8'h01;
    repeat (5) @(negedge core_clk_i);
    chk_val({ready, data, shift, chain, latch, bias, row, frame, off}, 32'h0);
    rst_i = 1'b0;
    // idle with words waiting: buffer fills, nothing shifts, display stays off
    push_words(3);
    repeat (12) @(negedge core_clk_i);
    chk_val(ready, 1'b0);
    chk_val(u_lpst_panel_model.got_q.size(), 0);
    chk_val(off, 1'b0);
    // each strap code, one frame of three lines; first pass has two chain groups
    for (int s = 0; s < 4; s++) begin
      straps = s[1:0];
      geom.groups_m1 = (s == 0) ? 8'h01 : 8'h00;
      n = 16 * (geom.groups_m1 + 1);
      base = u_lpst_panel_model.lines;
      push_words(3 * n - ((s == 0) ? 3 : 0));
      if (s == 0) begin
        on_cmd = 1'b1;
        @(negedge core_clk_i);
        on_cmd = 1'b0;
      end
      wait_lines(base + 3);
      chk_val(u_lpst_panel_model.line_shifts, n);
      chk_val(u_lpst_panel_model.line_chains, geom.groups_m1 + 1);
      chk_val(u_lpst_panel_model.frames, s + 1);
      chk_val(u_lpst_panel_model.hi_len, exp_half(s[1:0]));
      chk_val(off, 1'b1);
    end
    chk_val(u_lpst_panel_model.bias_gap, geom.bias_lines_m1 + 1);
    // power save in the gap just before a frame end; two frames of data keep lines moving
    base = u_lpst_panel_model.lines;
    w0 = exp_q.size();
    ps_cmd = 1'b1;
    @(negedge core_clk_i);
    ps_cmd = 1'b0;
    push_words(6 * n);
    while (off === 1'b1) @(negedge core_clk_i);
    n = u_lpst_panel_model.lines - base;
    chk_val((n >= 3) && (n <= 6), 1'b1);
    repeat (200) @(negedge core_clk_i);
    chk_val(off, 1'b0);
    // words beyond the last driven line stay queued, so only whole lines are owed
    chk_val(u_lpst_panel_model.got_q.size(), w0 + n * 16 * (geom.groups_m1 + 1));
    for (int i = 0; i < u_lpst_panel_model.got_q.size(); i++) chk_val(u_lpst_panel_model.got_q[i], exp_q[i]);
    final_report();
  end
endmodule
